// [hw/sccr_clock_reset.sv]
// Notes on behaviour
// R1: CPU clock is oscillator divided by 1, 2, 8 or 16.
// R2: Stop halts oscillator; only reset or filtered external interrupt restarts it.
// R3: Idle stops only the CPU clock; peripherals keep their clock.
// R4: Idle ends on reset or any external or internal interrupt.
// R5: Clock control register at D4H in set 1, readable and writable.
// R6: Bit 7 of clock control gates external-interrupt wake-up.
// R7: After reset wake-up enabled, oscillator running, divide by 16.
// R8: Software keeps signature bits 2..0 at 000B, never 101B.
// R9: Reset pin is synchronised, then filtered like a hysteresis stage.
// R10: Reset pin is held low at least 1 ms after power is valid.
// R11: Reset returns every control register to its default.
// R12: Reset disables all interrupt sources.
// R13: Reset enables the basic timer watchdog.
// R14: Reset makes all pins of ports 0 to 3 inputs.
// R15: Reset loads the program counter with 0100H.
// R16: First fetch waits for the stabilisation interval, then starts at 0100H.
// R17: Basic timer overflow resets while watchdog on; 1010B upper nibble turns it off. The code resets only in Run state, not in Idle.
// R18: Software sets the stabilisation interval before entering Stop.
// R19: Reset zeroes every bit; unused bits store written values like the rest.
// R20: Stop instruction with stop control halts CPU and peripherals, keeping registers except stop control, which clears.
// R21: Divide ratio changes never shorten a CPU clock pulse.
`timescale 1ns/1ps
`default_nettype none
module sccr_clock_reset #(
   parameter int BT_BITS = 8,
   parameter int PIN_FILT = sccr_pkg::SCCR_PIN_FILT_CYC,
   parameter int IRQ_FILT = sccr_pkg::SCCR_IRQ_FILT_CYC
) (
   // Clock and block reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // External reset pin, interrupts
   input wire logic reset_pin_n,
   input wire logic ext_irq,
   input wire logic int_irq,
   // Power-down instructions from the CPU
   input wire logic stop_instr,
   input wire logic idle_instr,
   // CPU register file port
   input wire logic [7:0] reg_addr,
   input wire logic reg_bank,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Clock strobes
   output logic cpu_tick,
   output logic periph_tick,
   output logic osc_run,
   // Reset sequence outputs
   output logic sys_reset,
   output logic int_disable_all,
   output logic port_force_input,
   output logic wdt_enabled,
   output logic pc_load,
   output logic [15:0] pc_vector,
   output logic fetch_en
);
   import sccr_pkg::*;

   sccr_state_t state;
   sccr_state_t next_state;
   logic [7:0] clk_ctl;
   logic [7:0] bt_ctl;
   logic [7:0] stop_ctl;
   logic [1:0] pin_sync;
   logic pin_level;
   logic [3:0] pin_cnt;
   logic [3:0] irq_cnt;
   logic irq_filtered;
   logic [14:0] bt_pre;
   logic [BT_BITS-1:0] bt_cnt;
   logic bt_ovf;
   logic bt_tick;
   logic [3:0] div_cnt;
   logic wdt_rst;
   logic rst_req;
   logic wr_clk;
   logic wr_bt;
   logic wr_stop;
   logic regs_rst;

   // Period minus one for a divider select code
   function automatic logic [3:0] div_reload(input logic [1:0] sel);
      unique case (sel)
         SCCR_SEL_DIV16: div_reload = 4'hF;
         SCCR_SEL_DIV8: div_reload = 4'h7;
         SCCR_SEL_DIV2: div_reload = 4'h1;
         default: div_reload = 4'h0;
      endcase
   endfunction

   // Prescaler exponent for a basic timer select code
   function automatic logic [3:0] bt_exp(input logic [1:0] sel);
      unique case (sel)
         2'h0: bt_exp = SCCR_BT_EXP0;
         2'h1: bt_exp = SCCR_BT_EXP1;
         2'h2: bt_exp = SCCR_BT_EXP2;
         default: bt_exp = SCCR_BT_EXP3;
      endcase
   endfunction

   // Address decode; stop control lives in bank 0 only
   assign wr_clk = reg_wr && reg_addr == SCCR_ADDR_SYSTEM_CLOCK_CONTROL; // R5
   assign wr_bt = reg_wr && reg_addr == SCCR_ADDR_BASIC_TIMER_CONTROL;
   assign wr_stop = reg_wr && !reg_bank && reg_addr == SCCR_ADDR_STOP_CONTROL;
   assign regs_rst = !rst_n || sys_reset; // R11

   // Reset pin synchroniser; the first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_sync <= 2'h0;
      end else begin
         pin_sync <= {pin_sync[0], reset_pin_n}; // R9
      end
   end

   // Level changes only after PIN_FILT equal samples, like a hysteresis stage
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_level <= 1'b0;
         pin_cnt <= 4'h0;
      end else if (pin_sync[1] == pin_level) begin
         pin_cnt <= 4'h0;
      end else if (pin_cnt == 4'(PIN_FILT - 1)) begin
         pin_level <= pin_sync[1]; // R9
         pin_cnt <= 4'h0;
      end else begin
         pin_cnt <= pin_cnt + 4'h1;
      end
   end

   // External interrupt noise filter used for stop wake-up
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !ext_irq) begin
         irq_cnt <= 4'h0;
         irq_filtered <= 1'b0;
      end else if (irq_cnt == 4'(IRQ_FILT - 1)) begin
         irq_filtered <= 1'b1; // R2
      end else begin
         irq_cnt <= irq_cnt + 4'h1;
      end
   end

   // Internal reset request: pin low or watchdog overflow
   assign wdt_rst = bt_ovf && bt_ctl[7:4] != SCCR_WDT_OFF_KEY && state == SCCR_ST_RUN; // R17
   assign rst_req = !pin_level || wdt_rst;

   // Power and reset sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         SCCR_ST_RESET: begin
            if (!rst_req) begin
               next_state = SCCR_ST_STAB;
            end
         end
         SCCR_ST_STAB, SCCR_ST_WAKE: begin
            if (bt_ovf) begin
               next_state = SCCR_ST_RUN; // R16
            end
         end
         SCCR_ST_RUN: begin
            if (stop_instr && stop_ctl == SCCR_STOP_KEY) begin
               next_state = SCCR_ST_STOP; // R20
            end else if (idle_instr) begin
               next_state = SCCR_ST_IDLE; // R3
            end
         end
         SCCR_ST_IDLE: begin
            if (ext_irq || int_irq) begin
               next_state = SCCR_ST_RUN; // R4
            end
         end
         SCCR_ST_STOP: begin
            if (irq_filtered && !clk_ctl[SCCR_WAKE_DIS_BIT]) begin
               next_state = SCCR_ST_WAKE; // R2 R6
            end
         end
         default: next_state = SCCR_ST_RESET;
      endcase
      if (rst_req) begin
         next_state = SCCR_ST_RESET; // R2 R4
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= SCCR_ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Reset-phase outputs, registered so they start clean
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sys_reset <= 1'b1;
         int_disable_all <= 1'b1;
         port_force_input <= 1'b1;
      end else begin
         sys_reset <= next_state == SCCR_ST_RESET; // R11
         int_disable_all <= next_state == SCCR_ST_RESET; // R12
         port_force_input <= next_state == SCCR_ST_RESET; // R14
      end
   end

   // Program counter load and fetch release
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pc_vector <= SCCR_RESET_VECTOR;
         pc_load <= 1'b0;
         fetch_en <= 1'b0;
      end else begin
         pc_vector <= SCCR_RESET_VECTOR; // R15
         pc_load <= state == SCCR_ST_STAB && next_state == SCCR_ST_RUN; // R16
         fetch_en <= next_state == SCCR_ST_RUN || next_state == SCCR_ST_IDLE; // R16
      end
   end

   // System clock control register; all bits stored as written
   always_ff @(posedge clk_sys) begin
      if (regs_rst) begin
         clk_ctl <= SCCR_RESET_VALUE; // R7 R19
      end else if (wr_clk) begin
         clk_ctl <= reg_wdata; // R5 R8
      end
   end

   // Basic timer control; the clear bit acts once and reads back zero
   always_ff @(posedge clk_sys) begin
      if (regs_rst) begin
         bt_ctl <= SCCR_RESET_VALUE; // R13
      end else if (wr_bt) begin
         bt_ctl <= reg_wdata & ~(8'h01 << SCCR_BT_CLR_BIT); // R17 R18
      end
   end

   // Stop control is consumed when Stop is entered
   always_ff @(posedge clk_sys) begin
      if (regs_rst || state == SCCR_ST_STOP) begin
         stop_ctl <= SCCR_RESET_VALUE;
      end else if (wr_stop) begin
         stop_ctl <= reg_wdata; // R20
      end
   end

   // Register read data; unmapped addresses read zero with no hit
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else if (reg_rd) begin
         reg_hit <= 1'b1;
         if (reg_addr == SCCR_ADDR_SYSTEM_CLOCK_CONTROL) begin
            reg_rdata <= clk_ctl; // R5
         end else if (reg_addr == SCCR_ADDR_BASIC_TIMER_CONTROL) begin
            reg_rdata <= bt_ctl;
         end else if (!reg_bank && reg_addr == SCCR_ADDR_STOP_CONTROL) begin
            reg_rdata <= stop_ctl;
         end else begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
         end
      end else begin
         reg_hit <= 1'b0;
      end
   end

   // Basic timer: prescaled counter; overflow ends stabilisation or fires watchdog
   assign bt_tick = bt_pre[bt_exp(bt_ctl[SCCR_BT_SEL_LSB +: 2]) - 4'h1] &&
      (bt_pre & ((15'h1 << bt_exp(bt_ctl[SCCR_BT_SEL_LSB +: 2])) - 15'h1)) ==
      ((15'h1 << bt_exp(bt_ctl[SCCR_BT_SEL_LSB +: 2])) - 15'h1);
   assign bt_ovf = bt_tick && &bt_cnt;

   // Counter is cleared in Stop since the oscillator is off there
   always_ff @(posedge clk_sys) begin
      if (!rst_n || state == SCCR_ST_RESET || state == SCCR_ST_STOP) begin
         bt_pre <= 15'h0;
         bt_cnt <= '0;
      end else if (wr_bt && reg_wdata[SCCR_BT_CLR_BIT]) begin
         bt_pre <= 15'h0;
         bt_cnt <= '0;
      end else begin
         bt_pre <= bt_pre + 15'h1;
         if (bt_tick) begin
            bt_cnt <= bt_cnt + 1'b1; // R17
         end
      end
   end

   // CPU divider: ratio is reloaded only at a period end, so no short pulse
   always_ff @(posedge clk_sys) begin
      if (!rst_n || state == SCCR_ST_RESET) begin
         div_cnt <= div_reload(SCCR_SEL_DIV16); // R7
      end else if (osc_run) begin
         if (div_cnt == 4'h0) begin
            div_cnt <= div_reload(clk_ctl[SCCR_DIV_LSB +: 2]); // R1 R21
         end else begin
            div_cnt <= div_cnt - 4'h1;
         end
      end
   end

   // Clock strobes; Idle gates only the CPU strobe
   assign osc_run = state != SCCR_ST_STOP; // R2 R20
   assign cpu_tick = state == SCCR_ST_RUN && div_cnt == 4'h0; // R1 R3
   assign periph_tick = osc_run && state != SCCR_ST_RESET; // R3
   assign wdt_enabled = bt_ctl[7:4] != SCCR_WDT_OFF_KEY; // R13 R17
endmodule
`default_nettype wire

// [shared/sccr_pkg.sv]
package sccr_pkg;
   // Register map, CPU register set 1
   localparam logic [7:0] SCCR_ADDR_BASIC_TIMER_CONTROL = 8'hD3;
   localparam logic [7:0] SCCR_ADDR_SYSTEM_CLOCK_CONTROL = 8'hD4;
   localparam logic [7:0] SCCR_ADDR_STOP_CONTROL = 8'hFB;
   localparam logic [7:0] SCCR_RESET_VALUE = 8'h00;
   // system_clock_control fields
   localparam int SCCR_WAKE_DIS_BIT = 7;
   localparam int SCCR_DIV_LSB = 3;
   localparam logic [2:0] SCCR_SIG_INVALID = 3'h5;
   // Divider select codes and their periods
   localparam logic [1:0] SCCR_SEL_DIV16 = 2'h0;
   localparam logic [1:0] SCCR_SEL_DIV8 = 2'h1;
   localparam logic [1:0] SCCR_SEL_DIV2 = 2'h2;
   localparam logic [1:0] SCCR_SEL_DIV1 = 2'h3;
   // basic_timer_control fields
   localparam logic [3:0] SCCR_WDT_OFF_KEY = 4'hA;
   localparam int SCCR_BT_SEL_LSB = 2;
   localparam int SCCR_BT_CLR_BIT = 1;
   // Basic timer prescaler exponents per select code
   localparam logic [3:0] SCCR_BT_EXP0 = 4'hC;
   localparam logic [3:0] SCCR_BT_EXP1 = 4'hA;
   localparam logic [3:0] SCCR_BT_EXP2 = 4'h7;
   localparam logic [3:0] SCCR_BT_EXP3 = 4'h4;
   // Value of stop_control that arms the stop instruction
   localparam logic [7:0] SCCR_STOP_KEY = 8'hA5;
   // Program reset vector
   localparam logic [15:0] SCCR_RESET_VECTOR = 16'h0100;
   // Minimum reset pin low time (other party) and its cycle count
   localparam int SCCR_CLK_NS = 50;
   localparam int SCCR_RESET_MIN_NS = 1000000;
   localparam int SCCR_RESET_MIN_CYC = SCCR_RESET_MIN_NS / SCCR_CLK_NS;
   // Filter lengths
   localparam int SCCR_PIN_FILT_CYC = 4;
   localparam int SCCR_IRQ_FILT_CYC = 8;

   typedef enum logic [5:0] {
      SCCR_ST_RESET = 6'b000001,
      SCCR_ST_STAB = 6'b000010,
      SCCR_ST_RUN = 6'b000100,
      SCCR_ST_IDLE = 6'b001000,
      SCCR_ST_STOP = 6'b010000,
      SCCR_ST_WAKE = 6'b100000
   } sccr_state_t;
endpackage

// [test/sccr_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sccr_chk (
   // Clock, reset, pins
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reset_pin_n,
   input wire logic ext_irq,
   input wire logic int_irq,
   input wire logic stop_instr,
   input wire logic idle_instr,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_hit,
   // Strobes and reset outputs
   input wire logic cpu_tick,
   input wire logic osc_run,
   input wire logic sys_reset,
   input wire logic int_disable_all,
   input wire logic port_force_input,
   input wire logic wdt_enabled,
   input wire logic pc_load,
   input wire logic [15:0] pc_vector,
   input wire logic fetch_en
);
   import sccr_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [4:0] gap;
   logic gap_ok;
   // Gap since last tick; trusted only across uninterrupted running
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gap <= 5'h00;
         gap_ok <= 1'b0;
      end else begin
         gap <= cpu_tick ? 5'h01 : (gap == 5'h1F ? gap : gap + 5'h01);
         gap_ok <= (gap_ok | cpu_tick) & fetch_en & osc_run & ~idle_instr & ~stop_instr;
      end
   end
   // Named steps
   sequence s_pin_low; !reset_pin_n [*8]; endsequence
   sequence s_idle_go; idle_instr && fetch_en && !stop_instr && !ext_irq && !int_irq; endsequence
   property p_pin; s_pin_low |-> ##[0:4] sys_reset; endproperty
   property p_idle; s_idle_go |=> !cpu_tick && fetch_en; endproperty
   property p_gap; cpu_tick && gap_ok |-> gap inside {5'h01, 5'h02, 5'h08, 5'h10}; endproperty
   property p_rd; reg_rd && reg_addr == SCCR_ADDR_SYSTEM_CLOCK_CONTROL |=> reg_hit; endproperty
   property p_osc; $fell(osc_run) |-> $past(stop_instr); endproperty
   // Registers clear on the edge after sys_reset rises, so the watchdog flag lags a cycle
   property p_rst;
      sys_reset |-> int_disable_all && port_force_input && !fetch_en ##1 wdt_enabled;
   endproperty
   property p_vec; pc_load |-> pc_vector == SCCR_RESET_VECTOR && !sys_reset ##1 fetch_en; endproperty
   property p_wake;
      (ext_irq || int_irq) && fetch_en && !stop_instr && !idle_instr |-> ##[0:24] cpu_tick;
   endproperty
   a_pin: assert property (p_pin) else $error("pin low not taken");
   a_idle: assert property (p_idle) else $error("idle kept ticking");
   a_gap: assert property (p_gap) else $error("bad tick gap");
   a_rd: assert property (p_rd) else $error("clock reg not hit");
   a_osc: assert property (p_osc) else $error("osc stopped unasked");
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
   a_vec: assert property (p_vec) else $error("bad vector load");
   a_wake: assert property (p_wake) else $error("no wake on irq");
endmodule
bind sccr_clock_reset sccr_chk sccr_chk_inst (.clk_sys, .rst_n, .reset_pin_n, .ext_irq,
   .int_irq, .stop_instr, .idle_instr, .reg_addr, .reg_rd, .reg_hit, .cpu_tick, .osc_run,
   .sys_reset, .int_disable_all, .port_force_input, .wdt_enabled, .pc_load, .pc_vector,
   .fetch_en);
`default_nettype wire

// [test/sccr_clock_reset_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sccr_clock_reset_tb;
   import sccr_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, press = 1'b0, reset_pin_n;
   logic ext_irq = 1'b0, int_irq = 1'b0, stop_instr = 1'b0, idle_instr = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_bank = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_hit, cpu_tick, periph_tick;
   logic osc_run, sys_reset, int_disable_all, port_force_input, wdt_enabled, pc_load, fetch_en;
   logic [15:0] pc_vector;
   int fails = 0, n_tests = 0;
   always #25 clk_sys = ~clk_sys;
   // Pin model keeps the full 1 ms hold, so every pin reset costs about 20000 cycles
   sccr_pin_model sccr_pin_model_inst (.clk_sys, .press, .reset_pin_n);
   sccr_clock_reset #(.BT_BITS(2)) sccr_clock_reset_inst (.clk_sys, .rst_n, .reset_pin_n,
      .ext_irq, .int_irq, .stop_instr, .idle_instr, .reg_addr, .reg_bank, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .reg_hit, .cpu_tick, .periph_tick, .osc_run, .sys_reset,
      .int_disable_all, .port_force_input, .wdt_enabled, .pc_load, .pc_vector, .fetch_en);
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return cpu_tick;
         1: return pc_load;
         2: return osc_run;
         3: return sys_reset;
         4: return !sys_reset;
         default: return fetch_en;
      endcase
   endfunction
   // Bounded wait; running out ends the run with a mismatch
   task automatic wait_for(input int k, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(negedge clk_sys);
         if (sig(k) === 1'b1) return;
      end
      $display("[ERR] wait %0d expected 1 seen 0", k);
      fails++;
      close_out();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
      @(negedge clk_sys);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("read data", d, reg_rdata);
      chk("read hit", h, reg_hit);
   endtask
   // k: 0 idle, 1 stop, 2 pin press
   task automatic pulse(input int k);
      @(negedge clk_sys);
      {press, stop_instr, idle_instr} = 3'b001 << k;
      @(negedge clk_sys);
      {press, stop_instr, idle_instr} = 3'b000;
   endtask
   // Watchdog is switched off during the wait so it cannot cut the run short
   task automatic boot();
      wait_for(4, 25000);
      wr(SCCR_ADDR_BASIC_TIMER_CONTROL, 8'hAC);
      chk("wdt", 0, wdt_enabled);
      chk("fetch held", 0, fetch_en);
      wait_for(1, 40000);
      chk("vector", SCCR_RESET_VECTOR, pc_vector);
      wait_for(5, 2);
   endtask
   task automatic gap(output int n);
      wait_for(0, 40);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (cpu_tick !== 1'b1 && n < 40);
   endtask
   initial begin
      int n;
      logic [1:0] sl[4] = '{SCCR_SEL_DIV16, SCCR_SEL_DIV8, SCCR_SEL_DIV2, SCCR_SEL_DIV1};
      int dv[4] = '{16, 8, 2, 1};
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      chk("reset flags", 4'hF, {sys_reset, int_disable_all, port_force_input, wdt_enabled});
      wr(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, 8'h18);
      rd(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, SCCR_RESET_VALUE, 1);
      rd(SCCR_ADDR_BASIC_TIMER_CONTROL, 8'h00, 1);
      boot();
      gap(n);
      chk("reset gap", 16, n);
      $display("test reset done");
      // Every divide ratio, measured after the new ratio has loaded
      for (int i = 0; i < 4; i++) begin
         wr(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, {3'b000, sl[i], 3'b000});
         rd(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, {3'b000, sl[i], 3'b000}, 1);
         gap(n);
         gap(n);
         chk("gap", dv[i], n);
      end
      rd(8'h00, 8'h00, 0);
      reg_bank = 1'b1;
      rd(SCCR_ADDR_STOP_CONTROL, 8'h00, 0);
      rd(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, 8'h18, 1);
      reg_bank = 1'b0;
      $display("test divider done");
      // Idle left by an internal, then an external request
      for (int i = 0; i < 2; i++) begin
         pulse(0);
         // Sampled one by one so an unknown strobe cannot slip through a sum
         repeat (20) begin
            @(negedge clk_sys);
            chk("idle cpu_tick", 0, cpu_tick);
            chk("idle periph_tick", 1, periph_tick);
         end
         {ext_irq, int_irq} = i ? 2'b10 : 2'b01;
         wait_for(0, 20);
         {ext_irq, int_irq} = 2'b00;
      end
      $display("test idle done");
      wr(SCCR_ADDR_STOP_CONTROL, SCCR_STOP_KEY);
      pulse(1);
      chk("osc stop", 0, osc_run);
      ext_irq = 1'b1;
      wait_for(2, 30);
      ext_irq = 1'b0;
      wait_for(0, 400);
      rd(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, 8'h18, 1);
      $display("test stop done");
      // External wake refused; only the pin brings it back
      wr(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, 8'h98);
      wr(SCCR_ADDR_STOP_CONTROL, SCCR_STOP_KEY);
      pulse(1);
      ext_irq = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk("osc held", 0, osc_run);
      ext_irq = 1'b0;
      pulse(2);
      wait_for(3, 100);
      boot();
      rd(SCCR_ADDR_SYSTEM_CLOCK_CONTROL, SCCR_RESET_VALUE, 1);
      $display("test pin done");
      wr(SCCR_ADDR_BASIC_TIMER_CONTROL, 8'h0C);
      chk("wdt", 1, wdt_enabled);
      wait_for(3, 300);
      boot();
      $display("test watchdog done");
      close_out();
   end
endmodule
`default_nettype wire

// [test/sccr_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sccr_pin_model #(
   parameter int HOLD_CYC = sccr_pkg::SCCR_RESET_MIN_CYC
) (
   // Clock and press command
   input wire logic clk_sys,
   input wire logic press,
   // Reset pin, driven low then released
   output logic reset_pin_n
);
   int cnt = HOLD_CYC;
   // Full hold after power-up and after every press, so the oscillator can settle
   always @(posedge clk_sys) begin
      if (press) begin
         cnt <= HOLD_CYC;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign reset_pin_n = (cnt == 0);
endmodule
`default_nettype wire
